// file: core/dssc_cfg.svh
/*
 Timing counts and strap field layout for the select and spindle block.
 Assumes a 250 MHz local clock; included by bare name with a guard.
*/
`ifndef DSSC_CFG_SVH
`define DSSC_CFG_SVH
`define DSSC_CLK_MHZ 250
`define DSSC_SPINUP_MS 250
`define DSSC_LATCH_RUN_MS 5000
`define DSSC_SPINUP_CYC (`DSSC_SPINUP_MS * 1000 * `DSSC_CLK_MHZ)
`define DSSC_LATCH_RUN_CYC (`DSSC_LATCH_RUN_MS * 1000 * `DSSC_CLK_MHZ)
`define DSSC_NUM_UNITS 4
`define DSSC_CNT_W 32
`endif

// file: core/dssc_pkg.sv
/*
 Types for the select and spindle block.
 Assumes dssc_cfg.svh holds the numbers.
*/
package dssc_pkg;
    typedef enum logic [2:0] {
        DSSC_MOTOR_OFF = 3'h1,
        DSSC_MOTOR_SPINUP = 3'h2,
        DSSC_MOTOR_STABLE = 3'h4
    } dssc_motor_t;
endpackage : dssc_pkg

// file: core/dssc_sync.sv
/*
 Two-stage level synchroniser, WIDTH bits, reset to a constant.
 Assumes inputs may change at any time relative to clock.
*/
`timescale 1ns/1ps
module dssc_sync #(
    parameter int WIDTH = 1,
    parameter logic RESET_VALUE = 1'b1
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // First stage is read only by the second
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1 <= {WIDTH{RESET_VALUE}};
            sync_out <= {WIDTH{RESET_VALUE}};
        end
        else if (clock_enable)
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : dssc_sync

// file: core/dssc_top.sv
/*
 Drive select gating and spindle motor control for a daisy-chained
 flexible disk drive. Assumes a 250 MHz local clock, asynchronous
 controller lines, and a controller that keeps one select line low.
*/
// Function
// - Own select low enables drive electronics
// - Deselected: ignore inputs, disable outputs
// - Four select inputs, strap picks one
// - Run low: spin up, stable within 250ms
// - Run high: remove drive, coast down
// - Motor control ignores selection
// - Latch close runs motor five seconds
// - Drop step pulses while not selected
// - Activity indicator lit while selected
// - Jumper intact: always enabled, indicator still follows own select
`timescale 1ns/1ps
`include "dssc_cfg.svh"
module dssc_top #(
    parameter int NUM_UNITS = `DSSC_NUM_UNITS,
    parameter int SPINUP_CYC = `DSSC_SPINUP_CYC,
    parameter int LATCH_RUN_CYC = `DSSC_LATCH_RUN_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic [NUM_UNITS-1:0] unit_select_n,
    input wire logic [NUM_UNITS-1:0] unit_address_strap,
    input wire logic always_enable_jumper,
    input wire logic spindle_run_n,
    input wire logic latch_closed,
    input wire logic step_n,
    input wire logic write_enable_n,
    input wire logic [NUM_UNITS-1:0] status_in_n,
    output logic drive_selected,
    output logic logic_enabled,
    output logic activity_led,
    output logic step_accept,
    output logic write_enable_gated,
    output logic [NUM_UNITS-1:0] status_out_n,
    output logic [NUM_UNITS-1:0] status_out_en,
    output logic motor_drive,
    output logic motor_stable
);
    logic [NUM_UNITS-1:0] sel_sync_n;
    logic [3:0] ctl_sync;
    logic run_sync_n;
    logic latch_sync;
    logic step_sync_n;
    logic wen_sync_n;
    logic latch_prev;
    logic step_prev_n;
    logic sel_match;
    logic enabled;
    logic motor_req;
    logic [`DSSC_CNT_W-1:0] latch_cnt;
    logic [`DSSC_CNT_W-1:0] spin_cnt;
    logic [`DSSC_CNT_W-1:0] next_latch_cnt;
    logic [`DSSC_CNT_W-1:0] next_spin_cnt;
    logic latch_rise;
    dssc_pkg::dssc_motor_t motor_state;
    dssc_pkg::dssc_motor_t next_motor_state;

    // Both groups pass two flops before any logic looks at them
    dssc_sync #(.WIDTH(NUM_UNITS), .RESET_VALUE(1'b1)) u_sel_sync (
        .clock(clock),
        .reset_n(reset_n),
        .clock_enable(clock_enable),
        .async_in(unit_select_n),
        .sync_out(sel_sync_n)
    );
    dssc_sync #(.WIDTH(4), .RESET_VALUE(1'b1)) u_ctl_sync (
        .clock(clock),
        .reset_n(reset_n),
        .clock_enable(clock_enable),
        .async_in({spindle_run_n, ~latch_closed, step_n, write_enable_n}),
        .sync_out(ctl_sync)
    );
    assign run_sync_n = ctl_sync[3];
    assign latch_sync = ~ctl_sync[2];
    assign step_sync_n = ctl_sync[1];
    assign wen_sync_n = ctl_sync[0];

    // Only the strapped line counts; several straps give undefined use
    assign sel_match = |(~sel_sync_n & unit_address_strap);
    assign enabled = sel_match | always_enable_jumper;

    // Selection, enable and indicator outputs
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            drive_selected <= 1'b0;
            logic_enabled <= 1'b0;
            activity_led <= 1'b0;
        end
        else if (clock_enable)
        begin
            drive_selected <= sel_match;
            logic_enabled <= enabled;
            activity_led <= sel_match;
        end
    end

    // Step accepted on trailing edge, only when enabled and not writing
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            step_prev_n <= 1'b1;
            step_accept <= 1'b0;
            write_enable_gated <= 1'b0;
        end
        else if (clock_enable)
        begin
            step_prev_n <= step_sync_n;
            step_accept <= !step_prev_n && step_sync_n && enabled
                && wen_sync_n;
            write_enable_gated <= enabled && !wen_sync_n;
        end
    end

    // Status lines released, not driven, while disabled (deselected, jumper removed)
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_out_n <= {NUM_UNITS{1'b1}};
            status_out_en <= '0;
        end
        else if (clock_enable)
        begin
            status_out_n <= enabled ? status_in_n : {NUM_UNITS{1'b1}};
            status_out_en <= {NUM_UNITS{enabled}};
        end
    end

    // Closure edge taken on the synchronised level only
    assign latch_rise = latch_sync && !latch_prev;

    // Next latch count; a fresh closure reloads rather than extends
    always_comb
    begin
        next_latch_cnt = latch_cnt;
        if (latch_rise)
            next_latch_cnt = `DSSC_CNT_W'(LATCH_RUN_CYC);
        else if (latch_cnt != '0)
            next_latch_cnt = latch_cnt - `DSSC_CNT_W'(1);
    end

    // Latch run timer; opening the latch does not cut the run short
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            latch_prev <= 1'b0;
            latch_cnt <= '0;
        end
        else if (clock_enable)
        begin
            latch_prev <= latch_sync;
            latch_cnt <= next_latch_cnt;
        end
    end

    // Run line or timer runs the motor; no select term on purpose
    assign motor_req = !run_sync_n || (latch_cnt != '0);

    // Motor sequencing
    always_comb
    begin
        next_motor_state = motor_state;
        case (motor_state)
            dssc_pkg::DSSC_MOTOR_OFF:
                if (motor_req)
                    next_motor_state = dssc_pkg::DSSC_MOTOR_SPINUP;
            dssc_pkg::DSSC_MOTOR_SPINUP:
                if (!motor_req)
                    next_motor_state = dssc_pkg::DSSC_MOTOR_OFF;
                else if (spin_cnt == '0)
                    next_motor_state = dssc_pkg::DSSC_MOTOR_STABLE;
            dssc_pkg::DSSC_MOTOR_STABLE:
                if (!motor_req)
                    next_motor_state = dssc_pkg::DSSC_MOTOR_OFF;
            default:
                next_motor_state = dssc_pkg::DSSC_MOTOR_OFF;
        endcase
    end

    // Spin-up deadline, kept loaded while off so entry needs no extra cycle
    always_comb
    begin
        next_spin_cnt = spin_cnt;
        if (motor_state == dssc_pkg::DSSC_MOTOR_OFF)
            next_spin_cnt = `DSSC_CNT_W'(SPINUP_CYC - 2);
        else if (spin_cnt != '0)
            next_spin_cnt = spin_cnt - `DSSC_CNT_W'(1);
    end

    // Stable flagged by the deadline; no speed sensor is modelled
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            motor_state <= dssc_pkg::DSSC_MOTOR_OFF;
            spin_cnt <= '0;
            motor_drive <= 1'b0;
            motor_stable <= 1'b0;
        end
        else if (clock_enable)
        begin
            motor_state <= next_motor_state;
            spin_cnt <= next_spin_cnt;
            motor_drive <= next_motor_state !=
                dssc_pkg::DSSC_MOTOR_OFF;
            motor_stable <= next_motor_state ==
                dssc_pkg::DSSC_MOTOR_STABLE;
        end
    end
endmodule : dssc_top

// file: sim/dssc_checker.sv
/*
 Port assertions for the select and spindle block.
 Assumes it is bound into dssc_top; clock_enable low pauses the checks.
*/
`timescale 1ns/1ps
module dssc_checker #(
    parameter int NUM_UNITS = 4,
    parameter int SPINUP_CYC = 20
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic [NUM_UNITS-1:0] unit_select_n,
    input wire logic [NUM_UNITS-1:0] unit_address_strap,
    input wire logic always_enable_jumper,
    input wire logic spindle_run_n,
    input wire logic drive_selected,
    input wire logic logic_enabled,
    input wire logic activity_led,
    input wire logic step_accept,
    input wire logic [NUM_UNITS-1:0] status_out_n,
    input wire logic [NUM_UNITS-1:0] status_out_en,
    input wire logic motor_drive,
    input wire logic motor_stable
);
    wire logic own = |(~unit_select_n & unit_address_strap);
    int run_cnt;
    // Cycles of motor drive, to time the stable report
    always_ff @(posedge clock or negedge reset_n)
        if (!reset_n)
            run_cnt <= 0;
        else if (clock_enable)
            run_cnt <= motor_drive ? run_cnt + 1 : 0;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n || !clock_enable);
    a_sel_latency: assert property (own [*4] |-> drive_selected)
        else $error("own select not seen");
    a_led_tracks: assert property (activity_led == drive_selected)
        else $error("led differs from select");
    a_led_dark: assert property ((!own) [*6] |-> !activity_led)
        else $error("led lit without own select");
    a_en_covers: assert property (drive_selected |-> logic_enabled)
        else $error("selected but disabled");
    a_desel_quiet: assert property ((!own && !always_enable_jumper) [*6]
        |-> !logic_enabled && !step_accept)
        else $error("deselected drive active");
    a_bus_released: assert property (!logic_enabled
        |-> status_out_en == '0 && status_out_n == '1)
        else $error("status driven while disabled");
    a_step_single: assert property (step_accept |=> !step_accept)
        else $error("step pulse too long");
    a_run_starts: assert property (!spindle_run_n [*4] |-> motor_drive)
        else $error("motor not driven");
    a_stable_time: assert property ($rose(motor_stable)
        |-> run_cnt == SPINUP_CYC - 1)
        else $error("stable at wrong time");
    a_stop_clears: assert property (!motor_drive |-> !motor_stable)
        else $error("stable without drive");
endmodule : dssc_checker
bind dssc_top dssc_checker #(.NUM_UNITS(NUM_UNITS), .SPINUP_CYC(SPINUP_CYC))
    u_chk (.clock, .reset_n, .clock_enable, .unit_select_n,
    .unit_address_strap, .always_enable_jumper, .spindle_run_n,
    .drive_selected, .logic_enabled, .activity_led, .step_accept,
    .status_out_n, .status_out_en, .motor_drive, .motor_stable);

// file: sim/dssc_ctrl_model.sv
/*
 Disk controller model: select, motor run and step lines.
 Assumes requests from the bench; lines change 1 ns after an edge.
*/
`timescale 1ns/1ps
module dssc_ctrl_model (
    input wire logic clock,
    input wire logic [1:0] unit,
    input wire logic sel,
    input wire logic run,
    input wire logic step,
    output logic [3:0] unit_select_n = 4'hF,
    output logic spindle_run_n = 1'b1,
    output logic step_n = 1'b1
);
    // One line low at most, held while sel stays up
    always @(posedge clock)
    begin
        unit_select_n <= #1 sel ? ~(4'h1 << unit) : 4'hF;
        spindle_run_n <= #1 !run;
        step_n <= #1 !step;
    end
endmodule : dssc_ctrl_model

// file: sim/drive_select_and_spindle_control_tb.sv
/*
 Self-checking bench for dssc_top with short spin and latch counts.
 Assumes dssc_ctrl_model drives the select, run and step lines.
*/
`timescale 1ns/1ps
module drive_select_and_spindle_control_tb;
    localparam int SPIN = 20;
    localparam int LRUN = 50;
    logic clock = 0, reset_n = 0, sel = 0, run = 0, step = 0, es, ee;
    logic always_enable_jumper = 0, latch_closed = 0, write_enable_n = 1;
    logic ce = 1;
    logic [3:0] unit_address_strap = 4'h1, status_in_n = 4'h5;
    logic [1:0] unit = 0;
    wire logic [3:0] unit_select_n, status_out_n, status_out_en;
    wire logic spindle_run_n, step_n, drive_selected, logic_enabled;
    wire logic activity_led, step_accept, motor_drive, motor_stable, weg;
    int n_errors = 0, tests_run = 0, c;
    // strap, unit, sel, jumper, expected select, expected enable
    logic [9:0] rows [6] = '{10'h04B, 10'h058, 10'h23B, 10'h120, 10'h08D,
        10'h09F};
    dssc_ctrl_model u_ctrl (.clock, .unit, .sel, .run, .step,
        .unit_select_n, .spindle_run_n, .step_n);
    dssc_top #(.SPINUP_CYC(SPIN), .LATCH_RUN_CYC(LRUN)) DUT (.clock,
        .reset_n, .clock_enable(ce), .unit_select_n, .unit_address_strap,
        .always_enable_jumper, .spindle_run_n, .latch_closed, .step_n,
        .write_enable_n, .status_in_n, .drive_selected, .logic_enabled,
        .activity_led, .step_accept, .write_enable_gated(weg), .status_out_n,
        .status_out_en, .motor_drive, .motor_stable);
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk
    // One step pulse, then count accepts seen
    task automatic steps();
        step = 1;
        tick(3);
        step = 0;
        c = 0;
        repeat (8)
        begin
            tick(1);
            c += step_accept;
        end
    endtask : steps
    task automatic report_and_stop();
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // Free-running 250 MHz clock
    initial
        forever #2 clock = ~clock;
    // Hang guard, well past the expected run length
    initial
    begin
        #4000;
        n_errors++;
        report_and_stop();
    end
    initial
    begin
        tick(4);
        reset_n = 1;
        foreach (rows[i])
        begin
            {unit_address_strap, unit, sel, always_enable_jumper, es, ee}
                = rows[i];
            tick(6);
            chk(drive_selected === es && activity_led === es, "sel");
            chk(status_out_en === {4{ee}}, "en");
            chk(status_out_n === (ee ? 4'h5 : 4'hF), "status");
        end
        {unit_address_strap, unit, sel, always_enable_jumper} = 8'h12;
        steps();
        chk(c === 1, "step");
        write_enable_n = 0;
        steps();
        chk(c === 0, "step writing");
        chk(weg === 1'b1, "wen gated");
        write_enable_n = 1;
        sel = 0;
        steps();
        chk(c === 0, "step deselected");
        write_enable_n = 0;
        tick(4);
        chk(weg === 1'b0, "wen deselected");
        write_enable_n = 1;
        run = 1;
        tick(5);
        chk(motor_drive === 1 && motor_stable === 0, "spin");
        tick(SPIN);
        chk(motor_stable === 1, "stable");
        run = 0;
        tick(5);
        chk(motor_drive === 0 && motor_stable === 0, "stop");
        latch_closed = 1;
        tick(LRUN - 4);
        chk(motor_drive === 1, "latch run");
        latch_closed = 0;
        tick(3);
        latch_closed = 1;
        tick(40);
        chk(motor_drive === 1, "latch restart");
        tick(20);
        chk(motor_drive === 0, "latch end");
        latch_closed = 0;
        tick(3);
        latch_closed = 1;
        run = 1;
        sel = 1;
        tick(LRUN + 10);
        chk(motor_drive === 1, "run override");
        reset_n = 0;
        tick(1);
        chk(motor_drive === 0 && drive_selected === 0, "reset");
        chk(status_out_n === 4'hF && status_out_en === 4'h0, "rst bus");
        reset_n = 1;
        tick(5);
        chk(motor_drive === 1 && drive_selected === 1, "resume");
        // Enable low must hold drive_selected and motor_drive through a deselect
        ce = 0;
        sel = 0;
        tick(6);
        chk(drive_selected === 1 && motor_drive === 1, "frozen");
        ce = 1;
        tick(5);
        chk(drive_selected === 0, "thawed");
        report_and_stop();
    end
endmodule : drive_select_and_spindle_control_tb
